// ===== epp_legacy_read_cycle.v
// legacy epp read-cycle sequencer with byte fifo towards the host
//
// Overview of operation
// RL1: peripheral wait low holds iochrdy low
// RL2: read finishes only after wait returns high; code also ends it on watchdog timeout with wait still low
// RL3: direction bit set: write indicator high, bus released
// RL4: host addresses epp register, then asserts read
// RL5: strobe asserted once bus released, direction high
// RL6: iochrdy low until wait high or timeout
// RL7: peripheral drives data, then deasserts wait
// RL8: strobe released only when host read ends
// RL9: peripheral releases bus after strobe ends
// RL10: outputs may change after cycle ends
// RL11: write indicator low only for writes
// RL12: interrupt passed through, active high, uninverted
// RL13: peripheral wait high means transfer done
// RL14: data strobe for data, address strobe for address
// RL15: active-low peripheral reset output provided
// RL16: direction low unless direction bit or read
// RL17: only write indicator overridable by control port
// RL18: software keeps direction bit low for reads
// RL19: watchdog aborts cycles over 10 us, status bit
// RL20: software clears control bits d0, d1, d3
// RL21: wait and interrupt pass two-flop synchronisers
`timescale 1ns/1ps
`include "epp_read_map.vh"
module epp_legacy_read_cycle (
   input wire core_clk_i,
   input wire rst_b_i,
   input wire epp_sel_i,
   input wire addr_sel_i,
   input wire ior_n_i,
   input wire iow_n_i,
   input wire [7:0] ctrl_reg_i,
   input wire spp_write_force_i,
   input wire periph_reset_req_i,
   input wire timeout_clr_i,
   input wire [7:0] pd_i,
   input wire peripheral_wait_n_i,
   input wire peripheral_irq_in_i,
   input wire host_ready_i,
   output reg iochrdy_o,
   output reg write_indicator_n_o,
   output reg data_strobe_n_o,
   output reg addr_strobe_n_o,
   output reg port_direction_out_o,
   output reg pd_oe_o,
   output reg periph_reset_n_o,
   output reg irq_o,
   output reg timeout_o,
   output reg [7:0] system_data_bus_o,
   output reg system_data_valid_o,
   output reg fifo_full_o
);
   localparam ST_IDLE = 2'b00;
   localparam ST_STROBE = 2'b01;
   localparam ST_HOLD = 2'b10;
   localparam ST_DRAIN = 2'b11;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [`WDOG_CNT_W-1:0] wdog_r;
   reg addr_cycle_r;
   reg captured_r;
   reg timed_out_r;
   wire wait_n_s;
   wire irq_s;
   wire ior_n_s;
   wire iow_n_s;
   wire [7:0] pd_s;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire dir_bit;
   wire read_start;
   wire wdog_expired;
   wire capture;
   wire in_cycle;

   epp_sync2 #(.RST_VAL(1'b1)) u_sync_wait (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(peripheral_wait_n_i),
      .q_o(wait_n_s)
   ); // RL21
   epp_sync2 #(.RST_VAL(1'b0)) u_sync_irq (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(peripheral_irq_in_i),
      .q_o(irq_s)
   ); // RL21
   epp_sync2 #(.RST_VAL(1'b1)) u_sync_ior (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(ior_n_i),
      .q_o(ior_n_s)
   );
   epp_sync2 #(.RST_VAL(1'b1)) u_sync_iow (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(iow_n_i),
      .q_o(iow_n_s)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pd_sync
         epp_sync2 #(.RST_VAL(1'b0)) u_sync_pd (
            .core_clk_i(core_clk_i),
            .rst_b_i(rst_b_i),
            .d_i(pd_i[gi]),
            .q_o(pd_s[gi])
         );
      end
   endgenerate

   assign dir_bit = ctrl_reg_i[`CTRL_DIR_BIT];
   assign read_start = epp_sel_i && !ior_n_s && fifo_in_ready; // RL4
   assign wdog_expired = (wdog_r >= `WATCHDOG_CYCLES);
   assign in_cycle = (state_r == ST_STROBE) || (state_r == ST_HOLD);
   // data is taken once the peripheral signals valid with wait high
   assign capture = (state_r == ST_STROBE) && wait_n_s && !captured_r; // RL2 RL7 RL13

   epp_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .in_data_i(pd_s),
      .in_valid_i(capture),
      .in_ready_o(fifo_in_ready),
      .out_data_o(fifo_out_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(host_ready_i && !system_data_valid_o)
   );

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (read_start) begin
               state_nxt = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (wdog_expired) begin
               state_nxt = ST_HOLD; // RL19
            end else if (ior_n_s) begin
               state_nxt = ST_DRAIN; // RL8
            end else if (captured_r) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (ior_n_s) begin
               state_nxt = ST_DRAIN; // RL8
            end
         end
         ST_DRAIN: begin
            state_nxt = ST_IDLE; // RL10
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         state_r <= ST_IDLE;
         wdog_r <= {`WDOG_CNT_W{1'b0}};
         addr_cycle_r <= 1'b0;
         captured_r <= 1'b0;
         timed_out_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE) begin
            wdog_r <= {`WDOG_CNT_W{1'b0}};
            captured_r <= 1'b0;
            if (read_start) begin
               addr_cycle_r <= addr_sel_i; // RL14
            end
         end else if (in_cycle && !wdog_expired) begin
            wdog_r <= wdog_r + {{(`WDOG_CNT_W-1){1'b0}}, 1'b1}; // RL19
         end
         if (capture) begin
            captured_r <= 1'b1;
         end
         // expiry wins over a clear in the same cycle
         if (in_cycle && wdog_expired && !captured_r) begin
            timed_out_r <= 1'b1; // RL19
         end else if (timeout_clr_i) begin
            timed_out_r <= 1'b0;
         end
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         iochrdy_o <= 1'b1;
         write_indicator_n_o <= 1'b1;
         data_strobe_n_o <= 1'b1;
         addr_strobe_n_o <= 1'b1;
         port_direction_out_o <= 1'b0;
         pd_oe_o <= 1'b0;
         periph_reset_n_o <= 1'b0;
         irq_o <= 1'b0;
         timeout_o <= 1'b0;
         system_data_bus_o <= 8'h00;
         system_data_valid_o <= 1'b0;
         fifo_full_o <= 1'b0;
      end else begin
         // stretch host cycle while peripheral waits and no timeout
         iochrdy_o <= !(in_cycle && !captured_r && !wait_n_s && !wdog_expired); // RL1 RL6
         // only an spp write force may pull the write indicator low
         write_indicator_n_o <= !(spp_write_force_i && !dir_bit); // RL3 RL11 RL17
         data_strobe_n_o <= !(state_nxt == ST_STROBE || state_nxt == ST_HOLD) ||
            (state_r == ST_IDLE ? addr_sel_i : addr_cycle_r); // RL5 RL14
         addr_strobe_n_o <= !(state_nxt == ST_STROBE || state_nxt == ST_HOLD) ||
            !(state_r == ST_IDLE ? addr_sel_i : addr_cycle_r); // RL5 RL14
         port_direction_out_o <= dir_bit || (state_nxt != ST_IDLE); // RL16
         pd_oe_o <= !dir_bit && (state_nxt == ST_IDLE) && iow_n_s; // RL3
         periph_reset_n_o <= !periph_reset_req_i; // RL15
         irq_o <= irq_s; // RL12
         timeout_o <= timed_out_r; // RL19
         fifo_full_o <= !fifo_in_ready;
         if (!system_data_valid_o && host_ready_i && fifo_out_valid) begin
            system_data_bus_o <= fifo_out_data;
            system_data_valid_o <= 1'b1;
         end else begin
            system_data_valid_o <= 1'b0;
         end
      end
   end
endmodule

// ===== epp_read_map.vh
// constants for the legacy epp read-cycle sequencer
`ifndef EPP_READ_MAP_VH
`define EPP_READ_MAP_VH
`define CLK_PERIOD_PS 8000
`define WATCHDOG_TIME_NS 10000
`define WATCHDOG_CYCLES ((`WATCHDOG_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define WDOG_CNT_W 11
`define CTRL_DIR_BIT 5
`define STAT_TIMEOUT_BIT 0
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// ===== epp_sync2.v
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module epp_sync2 #(
   parameter RST_VAL = 1'b0
) (
   input wire core_clk_i,
   input wire rst_b_i,
   input wire d_i,
   output reg q_o
);
   reg meta_r;
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         meta_r <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule

// ===== epp_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module epp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire core_clk_i,
   input wire rst_b_i,
   input wire [WIDTH-1:0] in_data_i,
   input wire in_valid_i,
   output wire in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire out_valid_o,
   input wire out_ready_i
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push;
   wire pop;
   assign in_ready_o = (count_r != DEPTH[AW:0]);
   assign out_valid_o = (count_r != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end
   always @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push && !pop) begin
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         end else if (pop && !push) begin
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ===== epp_legacy_read_cycle_assertions.sv
// concurrent checks on the epp read-cycle sequencer ports
`timescale 1ns/1ps
module epp_read_checker (
   input wire core_clk_i,
   input wire rst_b_i,
   input wire ior_n_i,
   input wire [7:0] ctrl_reg_i,
   input wire spp_write_force_i,
   input wire peripheral_wait_n_i,
   input wire peripheral_irq_in_i,
   input wire iochrdy_o,
   input wire write_indicator_n_o,
   input wire data_strobe_n_o,
   input wire addr_strobe_n_o,
   input wire port_direction_out_o,
   input wire pd_oe_o,
   input wire irq_o,
   input wire timeout_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   strobe_dir_a: assert property (!data_strobe_n_o |-> port_direction_out_o && !pd_oe_o)
      else $error("strobe active without read direction");
   wait_stretch_a: assert property ((!data_strobe_n_o && !peripheral_wait_n_i && !timeout_o) [*4]
      |-> !iochrdy_o or ##1 timeout_o)
      else $error("iochrdy high while wait low");
   strobe_hold_a: assert property (!data_strobe_n_o && !ior_n_i |=> !data_strobe_n_o)
      else $error("strobe released before host read end");
   strobe_release_a: assert property ($rose(ior_n_i) |-> ##[1:5] data_strobe_n_o && addr_strobe_n_o)
      else $error("strobe not released after host read end");
   strobe_excl_a: assert property (!(!data_strobe_n_o && !addr_strobe_n_o))
      else $error("both strobes active");
   dir_idle_a: assert property ((!ctrl_reg_i[5] && ior_n_i) [*8] |-> !port_direction_out_o)
      else $error("direction high while idle");
   chrdy_cause_a: assert property (!iochrdy_o |-> !data_strobe_n_o || !addr_strobe_n_o)
      else $error("iochrdy low outside a cycle");
   irq_pass_a: assert property (irq_o == $past(peripheral_irq_in_i, 3))
      else $error("interrupt not passed through");
   write_ind_a: assert property (!spp_write_force_i [*3] |-> write_indicator_n_o)
      else $error("write indicator low without override");
endmodule
bind epp_legacy_read_cycle epp_read_checker chk_u (.*);

// ===== epp_periph_model.sv
// behavioural epp peripheral answering read strobes
`timescale 1ns/1ps
module epp_periph_model (
   input wire core_clk_i,
   input wire data_strobe_n_i,
   input wire addr_strobe_n_i,
   input wire hang_i,
   input wire [7:0] byte_i,
   input wire [7:0] dly_i,
   output reg [7:0] pd_o,
   output reg wait_n_o
);
   reg [7:0] cnt_r = 8'h00;
   initial pd_o = 8'h00;
   initial wait_n_o = 1'b0;
   always @(negedge core_clk_i) begin
      if (data_strobe_n_i && addr_strobe_n_i) begin
         cnt_r <= 8'h00;
         wait_n_o <= 1'b0;
         pd_o <= ~pd_o;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         if (cnt_r == dly_i) pd_o <= byte_i;
         if (cnt_r == dly_i + 8'h01 && !hang_i) wait_n_o <= 1'b1;
      end
   end
endmodule

// ===== tb_epp_legacy_read_cycle.sv
// testbench for the legacy epp read-cycle sequencer
`timescale 1ns/1ps
module tb_epp_legacy_read_cycle;
   reg clk = 0, rst_b = 0, sel = 0, asel = 0, ior_n = 1, frc = 0, prst = 0;
   reg tclr = 0, hrdy = 1, irq = 0, hang = 0;
   reg [7:0] ctrl = 8'h00, mb = 8'h00, md = 8'h00;
   wire [7:0] pd, sbus;
   wire wt_n, chrdy, wr_n, ds_n, as_n, port_direction_out, oe, prst_n, irq_o, tmo, sval, full;
   integer miscompares = 0, n_checks = 0, i, k, w;
   reg [7:0] q[$];
   always #4 clk = ~clk;
   always @(negedge clk) if (sval) q.push_back(sbus);
   epp_legacy_read_cycle dut_u (.core_clk_i(clk), .rst_b_i(rst_b), .epp_sel_i(sel),
      .addr_sel_i(asel), .ior_n_i(ior_n), .iow_n_i(1'b1), .ctrl_reg_i(ctrl),
      .spp_write_force_i(frc), .periph_reset_req_i(prst), .timeout_clr_i(tclr), .pd_i(pd),
      .peripheral_wait_n_i(wt_n), .peripheral_irq_in_i(irq), .host_ready_i(hrdy),
      .iochrdy_o(chrdy), .write_indicator_n_o(wr_n), .data_strobe_n_o(ds_n),
      .addr_strobe_n_o(as_n), .port_direction_out_o(port_direction_out), .pd_oe_o(oe),
      .periph_reset_n_o(prst_n), .irq_o(irq_o), .timeout_o(tmo), .system_data_bus_o(sbus),
      .system_data_valid_o(sval), .fifo_full_o(full));
   epp_periph_model peer_u (.core_clk_i(clk), .data_strobe_n_i(ds_n), .addr_strobe_n_i(as_n),
      .hang_i(hang), .byte_i(mb), .dly_i(md), .pd_o(pd), .wait_n_o(wt_n));
   task complete_run;
      begin
         $display("checks %0d miscompares %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task rd(input a, input [7:0] b, input [7:0] d, input [1:0] e);
      begin
         mb = b;
         md = d;
         asel = a;
         sel = 1'b1;
         ior_n = 1'b0;
         for (i = 0; i < 9 && ds_n && as_n; i = i + 1) @(negedge clk);
         chk({6'h00, ds_n, as_n}, {6'h00, e});
         chk({7'h00, port_direction_out}, {7'h00, ~&e});
         for (w = 0; w < 1400 && !(chrdy && (wt_n || tmo || ds_n && as_n)); w = w + 1)
            @(negedge clk);
         ior_n = 1'b1;
         sel = 1'b0;
         for (i = 0; i < 9 && !(ds_n && as_n); i = i + 1) @(negedge clk);
         repeat (2) @(negedge clk);
      end
   endtask
   task t_reads;
      begin
         rd(1'b0, 8'h5a, 8'h06, 2'b01);
         rd(1'b1, 8'ha5, 8'h00, 2'b10);
         repeat (6) @(negedge clk);
         chk(8'(q.size()), 8'h02);
         chk({7'h00, port_direction_out}, 8'h00);
         chk(q.pop_front(), 8'h5a);
         chk(q.pop_front(), 8'ha5);
      end
   endtask
   task t_fill;
      begin
         hrdy = 1'b0;
         for (k = 0; k < 16; k = k + 1) rd(1'b0, k[7:0], 8'h01, 2'b01);
         chk({7'h00, full}, 8'h01);
         rd(1'b0, 8'hee, 8'h01, 2'b11);
         hrdy = 1'b1;
         repeat (40) @(negedge clk);
         chk(8'(q.size()), 8'h10);
         chk({7'h00, full}, 8'h00);
         for (k = 0; k < 16; k = k + 1) chk(q.pop_front(), k[7:0]);
      end
   endtask
   task t_timeout;
      begin
         hang = 1'b1;
         rd(1'b0, 8'h11, 8'h00, 2'b01);
         hang = 1'b0;
         chk({7'h00, w > 1240 && w < 1260}, 8'h01);
         chk({7'h00, tmo}, 8'h01);
         chk(8'(q.size()), 8'h00);
         tclr = 1'b1;
         @(negedge clk);
         tclr = 1'b0;
         repeat (3) @(negedge clk);
         chk({7'h00, tmo}, 8'h00);
      end
   endtask
   task t_misc;
      begin
         ctrl = 8'h20;
         repeat (4) @(negedge clk);
         chk({5'h00, port_direction_out, oe, wr_n}, 8'h05);
         ctrl = 8'h00;
         frc = 1'b1;
         repeat (4) @(negedge clk);
         chk({7'h00, wr_n}, 8'h00);
         frc = 1'b0;
         irq = 1'b1;
         repeat (5) @(negedge clk);
         chk({7'h00, irq_o}, 8'h01);
         irq = 1'b0;
         prst = 1'b1;
         repeat (3) @(negedge clk);
         chk({7'h00, prst_n}, 8'h00);
         prst = 1'b0;
         repeat (3) @(negedge clk);
         chk({7'h00, prst_n}, 8'h01);
      end
   endtask
   initial begin
      #160000;
      miscompares = miscompares + 1;
      complete_run;
   end
   initial begin
      repeat (20) @(negedge clk);
      chk({chrdy, wr_n, ds_n, as_n, port_direction_out, oe, irq_o, tmo}, 8'hf0);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      t_reads;
      t_fill;
      t_timeout;
      t_misc;
      complete_run;
   end
endmodule
